// File: dv/spoc_asserts.sv
`timescale 1ns/10ps
module spoc_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic shift_clock_line_o,
  input wire logic shift_clock_line_oe_o,
  input wire logic simo_oe_o,
  input wire logic somi_oe_o,
  input wire logic irq_o
);
  logic [7:0] cfg_q, opc_q, msk_q;
  // accepted accesses and irq enables
  wire [15:0] idx_w = avs_address_i[17:2];
  wire we_w = !avs_waitrequest_o & avs_write_i & avs_byteenable_i[0];
  wire rd_w = !avs_waitrequest_o & avs_read_i;
  wire en_w = opc_q[4] & msk_q[7] | opc_q[0] & msk_q[6];
  // shadow of written control registers
  always_ff @(posedge core_clk_i) begin
    cfg_q <= !rst_n_i ? 8'h00 : (we_w && idx_w == 16'h7040) ? avs_writedata_i[7:0] : cfg_q;
    opc_q <= !rst_n_i ? 8'h00 : (we_w && idx_w == 16'h7041) ? avs_writedata_i[7:0] : opc_q;
    msk_q <= !rst_n_i ? 8'h00 : (we_w && idx_w == 16'h7043) ? avs_writedata_i[7:0] : msk_q;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wait; (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("request not answered");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_opc; rd_w && idx_w == 16'h7041 |-> avs_readdata_o == {27'h0, opc_q[4:0]}; endproperty
  a_opc: assert property (p_opc) else $error("operation control read wrong");
  property p_cfg; rd_w && idx_w == 16'h7040 |-> avs_readdata_o[3:0] == cfg_q[3:0]; endproperty
  a_cfg: assert property (p_cfg) else $error("length code read wrong");
  property p_slave; (!opc_q[2]) [*4] |-> !shift_clock_line_oe_o; endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock");
  property p_master; opc_q[2] [*4] |-> shift_clock_line_oe_o; endproperty
  a_master: assert property (p_master) else $error("master not driving clock");
  property p_idle; (!cfg_q[7] && $stable(cfg_q)) [*4] ##0 shift_clock_line_oe_o |-> shift_clock_line_o == cfg_q[6];
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level wrong");
  property p_irq; (!en_w) [*3] |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  property p_oe; simo_oe_o |-> shift_clock_line_oe_o && !somi_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("data enables clash");
  cover property (rd_w && idx_w == 16'h7041);
  cover property (shift_clock_line_oe_o && irq_o);
  cover property (somi_oe_o && irq_o);
endmodule : spoc_asserts
bind spoc_top spoc_asserts spoc_asserts_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .shift_clock_line_o(shift_clock_line_o),
  .shift_clock_line_oe_o(shift_clock_line_oe_o), .simo_oe_o(simo_oe_o), .somi_oe_o(somi_oe_o), .irq_o(irq_o));

// File: dv/spoc_peer.sv
`timescale 1ns/10ps
module spoc_peer (
  input wire logic run_i,
  input wire logic sclk_i,
  input wire logic data_i,
  output logic sclk_o,
  output logic data_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_q = 8'hA5;
  initial sclk_o = 1'b0;
  initial data_o = 1'b1;
  // external master clock, still low outside frames
  always #80 sclk_o = run_i ? ~sclk_o : 1'b0;
  // slave-side partner, polarity 0 phase 0: out on rise, sample on fall, msb first
  always @(posedge sclk_i) begin
    if (run_i) data_o <= sh_q[7];
  end
  always @(negedge sclk_i) begin
    if (run_i) sh_q <= {sh_q[6:0], data_i};
  end
  assign rx_o = sh_q;
endmodule : spoc_peer

// File: dv/spoc_tb_top.sv
`timescale 1ns/10ps
module spoc_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic run = 1'b0;
  logic last = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rq, q;
  logic wq, sck, sck_oe, mo, mo_oe, so, so_oe, irq, p_sck, p_d;
  logic [15:0] d;
  logic [7:0] v;
  logic [7:0] p_rx;
  int seed = 32'h4d1f;
  int mismatches = 0;
  int compares = 0;
  int edges = 0;
  int i, j, n, len, e0;
  // wire levels from all drivers
  wire line_w = sck_oe ? sck : p_sck;
  wire simo_w = mo_oe ? mo : p_d;
  wire somi_w = so_oe ? so : p_d;
  wire peer_in_w = mo_oe ? mo : so;
  always #10 clk = ~clk;
  spoc_top spoc_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rq),
    .avs_waitrequest_o(wq), .shift_clock_line_i(line_w), .shift_clock_line_o(sck),
    .shift_clock_line_oe_o(sck_oe), .simo_i(simo_w), .simo_o(mo), .simo_oe_o(mo_oe), .somi_i(somi_w),
    .somi_o(so), .somi_oe_o(so_oe), .irq_o(irq));
  spoc_peer spoc_peer_i (.run_i(run), .sclk_i(line_w), .data_i(peer_in_w), .sclk_o(p_sck), .data_o(p_d),
    .rx_o(p_rx));
  // count shift clock edges on the line
  always @(posedge clk) begin
    last <= line_w;
    if (line_w !== last) edges <= edges + 1;
  end
  // one avalon access, held until waitrequest low
  task bus(input logic w, input logic [15:0] a, input logic [15:0] dat, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {a, 2'b00};
    wd <= {16'h0, dat};
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    if (k >= 20) mismatches++;
    r = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      mismatches++;
    end
  endtask : chk
  task results;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 16'h7041, 0, q);
    chk(q, 32'h0);
    bus(0, 16'h7040, 0, q);
    chk(q, 32'h0);
    bus(1, 16'h7050, 16'h00FF, q);
    bus(0, 16'h7050, 0, q);
    chk(q, 32'h0);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      bus(1, 16'h7041, {8'h0, v}, q);
      bus(0, 16'h7041, 0, q);
      chk(q, {27'h0, v[4:0]});
    end
    bus(1, 16'h7043, 16'h00C0, q);
    // master transfers: len 1, 16, 8, random; both polarities and phases
    for (i = 0; i < 4; i++) begin
      len = (i == 0) ? 1 : (i == 1) ? 16 : (i == 2) ? 8 : ($random(seed) & 15) + 1;
      bus(1, 16'h7040, {8'h0, 1'b1, i[0], 2'b00, 4'(len - 1)}, q);
      if (i < 2) bus(0, 16'h7044, 0, q);
      // idle partner line is high, so the one-bit run received a single 1
      if (i < 2) chk(q, i);
      bus(1, 16'h7041, {11'h0, (i == 2), i[1], 2'b11, (i < 2)}, q);
      d = $random(seed);
      // phase 1 runs send two characters unread, so the second one overruns
      for (j = 0; j < 1 + i[1]; j++) begin
        e0 = edges;
        bus(1, 16'h7044, d, q);
        repeat (4) @(posedge clk);
        if (i[1]) chk(mo, d[len-1]);
        if (i[1]) chk(line_w, i[0]);
        n = 0;
        while (edges - e0 < 2 * len && n < 3000) begin
          @(posedge clk);
          n++;
        end
        repeat (10) @(posedge clk);
        chk(edges - e0, 2 * len);
      end
      chk(line_w, i[0]);
      chk(irq, (i < 3));
      bus(0, 16'h7042, 0, q);
      chk(q, {24'h0, (i > 1), 7'h40});
      repeat (3) @(posedge clk);
      chk(irq, 0);
      // next polarity set while held in soft reset, away from any counted window
      bus(1, 16'h7040, {8'h0, 1'b0, ~i[0], 6'h0}, q);
    end
    // slave: outside master makes the clock
    bus(0, 16'h7044, 0, q);
    bus(1, 16'h7040, 16'h0087, q);
    bus(1, 16'h7041, 16'h0003, q);
    bus(1, 16'h7044, 16'h003C, q);
    e0 = edges;
    run <= 1'b1;
    n = 0;
    while (edges - e0 < 16 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    run <= 1'b0;
    repeat (10) @(posedge clk);
    chk(sck_oe, 0);
    chk(so_oe, 1);
    chk(irq, 1);
    bus(0, 16'h7042, 0, q);
    chk(q, 32'h40);
    bus(0, 16'h7044, 0, q);
    chk(q, 32'hA5);
    chk(p_rx, 8'h3C);
    results;
  end
endmodule : spoc_tb_top

// File: hw/spoc_defs.svh
`ifndef SPOC_DEFS_SVH
`define SPOC_DEFS_SVH
// register indexes; byte address is four times the index
`define SPOC_IDX_CFG 16'h7040
`define SPOC_IDX_OPC 16'h7041
`define SPOC_IDX_STS 16'h7042
`define SPOC_IDX_MASK 16'h7043
`define SPOC_IDX_DATA 16'h7044
// config_control fields
`define SPOC_CFG_SWRST 7
`define SPOC_CFG_POL 6
`define SPOC_CFG_LEN_HI 3
`define SPOC_CFG_LEN_LO 0
// operation_control fields
`define SPOC_OPC_OVR_EN 4
`define SPOC_OPC_PHASE 3
`define SPOC_OPC_MASTER 2
`define SPOC_OPC_TALK 1
`define SPOC_OPC_INT_EN 0
`define SPOC_OPC_W 5
// port_status and mask fields
`define SPOC_STS_OVR 7
`define SPOC_STS_INT 6
// reset values
`define SPOC_CFG_RST 8'h00
`define SPOC_OPC_RST 5'h00
`define SPOC_MASK_RST 2'h0
// master half-period in core clocks
`define SPOC_HALF_DIV 4
`endif

// File: hw/spoc_pkg.sv
package spoc_pkg;
  // shift engine states
  typedef enum logic [0:0] {
    SPOC_IDLE = 1'b0,
    SPOC_SHIFT = 1'b1
  } spoc_state_t;
  // driven side of one pin
  typedef struct packed {
    logic o;
    logic oe;
  } spoc_pin_t;
  // edge events of the shift clock
  typedef struct packed {
    logic lead;
    logic trail;
  } spoc_edge_t;
endpackage : spoc_pkg

// File: hw/spoc_top.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "spoc_defs.svh"
// Function
// - the character length is the four-bit code plus one, from 1 to 16 bits.
// - bit 4 of operation control lets a hardware-set overrun flag raise the interrupt, and blocks it when 0.
// - overrun and transfer-complete interrupts leave on one shared interrupt output.
// - with phase 1 the first data bit is presented after the data register write and before the first clock edge.
// - with phase 1 the clock timing is shifted half a cycle, polarity still from the polarity bit.
// - with phase 0 the output and sample edges follow from the polarity bit alone.
// - bit 2 of operation control selects master when 1 and slave when 0.
// - after reset the port is a slave until software selects master.
// - bits 7 to 5 of operation control read as zero and ignore writes.
// - the length code sits in bits 3 to 0 of config control and sets bits per character.
// - with polarity 0 the shift clock idles low.
// - with polarity 1 the shift clock idles high.
// - polarity 0 phase 1 drives half a cycle before the first rise and on falls, and samples on rises.
module spoc_top #(
  parameter int HALF_DIV = `SPOC_HALF_DIV,
  parameter int LEN_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic shift_clock_line_i,
  output logic shift_clock_line_o,
  output logic shift_clock_line_oe_o,
  input wire logic simo_i,
  output logic simo_o,
  output logic simo_oe_o,
  input wire logic somi_i,
  output logic somi_o,
  output logic somi_oe_o,
  output logic irq_o
);
  localparam int CHR_W = 1 << LEN_W;
  localparam int CNT_W = $clog2(HALF_DIV + 1);

  // length code plus one
  function automatic logic [LEN_W:0] char_len(input logic [LEN_W-1:0] code);
    char_len = {1'b0, code} + {{LEN_W{1'b0}}, 1'b1};
  endfunction : char_len

  // picks one bit of the shift word by index
  function automatic logic bit_at(input logic [CHR_W-1:0] w, input logic [LEN_W-1:0] idx);
    bit_at = w[idx];
  endfunction : bit_at

  logic [7:0] cfg_q;
  logic [`SPOC_OPC_W-1:0] opc_q;
  logic ovr_q;
  logic intf_q;
  logic [1:0] mask_q;
  logic [CHR_W-1:0] rxbuf_q;
  logic rx_full_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;
  spoc_pkg::spoc_state_t st_q;
  logic [CNT_W-1:0] div_q;
  logic sclk_q;
  logic [CHR_W-1:0] sh_q;
  logic [LEN_W-1:0] bit_q;
  logic samp_q;
  logic out_q;
  spoc_pkg::spoc_pin_t sclk_pin_q;
  spoc_pkg::spoc_pin_t simo_pin_q;
  spoc_pkg::spoc_pin_t somi_pin_q;
  logic [2:0] sclk_s_q;
  logic [1:0] simo_s_q;
  logic [1:0] somi_s_q;

  // bus decode
  wire [15:0] word_idx = avs_address_i[17:2];
  wire req = avs_read_i | avs_write_i;
  wire acc = req & ~wait_q;
  wire wr_acc = acc & avs_write_i & avs_byteenable_i[0];
  wire rd_acc = acc & avs_read_i;
  wire hit_cfg = word_idx == `SPOC_IDX_CFG;
  wire hit_opc = word_idx == `SPOC_IDX_OPC;
  wire hit_sts = word_idx == `SPOC_IDX_STS;
  wire hit_mask = word_idx == `SPOC_IDX_MASK;
  wire hit_data = word_idx == `SPOC_IDX_DATA;
  wire [7:0] wbyte = avs_writedata_i[7:0];

  // settings
  wire swrst_n = cfg_q[`SPOC_CFG_SWRST];
  wire pol = cfg_q[`SPOC_CFG_POL];
  wire [LEN_W-1:0] len_code = cfg_q[`SPOC_CFG_LEN_HI:`SPOC_CFG_LEN_LO];
  wire [LEN_W:0] len = char_len(len_code);
  wire [LEN_W-1:0] top_idx = len_code;
  wire [LEN_W-1:0] next_idx = len_code - {{(LEN_W-1){1'b0}}, 1'b1};
  wire phase = opc_q[`SPOC_OPC_PHASE];
  wire master = opc_q[`SPOC_OPC_MASTER];
  wire talk = opc_q[`SPOC_OPC_TALK];

  // read mux; reserved bits read zero
  wire [7:0] sts_byte = {ovr_q, intf_q, 6'h00};
  wire [7:0] mask_byte = {mask_q, 6'h00};
  wire [7:0] cfg_byte = {cfg_q[7:6], 2'h0, cfg_q[3:0]};
  wire [7:0] opc_byte = {3'h0, opc_q};
  wire [31:0] rd_mux = hit_cfg ? {24'h000000, cfg_byte} :
                       hit_opc ? {24'h000000, opc_byte} :
                       hit_sts ? {24'h000000, sts_byte} :
                       hit_mask ? {24'h000000, mask_byte} :
                       hit_data ? {{(32-CHR_W){1'b0}}, rxbuf_q} : 32'h00000000;

  // master clock generator events
  wire m_tick = (st_q == spoc_pkg::SPOC_SHIFT) && (div_q == CNT_W'(HALF_DIV - 1));
  wire m_lead = m_tick & (sclk_q == pol);
  wire m_trail = m_tick & (sclk_q != pol);
  // slave edges from the synchronised clock pin
  wire s_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire s_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire s_lead = swrst_n & (pol ? s_fall : s_rise);
  wire s_trail = swrst_n & (pol ? s_rise : s_fall);
  spoc_pkg::spoc_edge_t edg;
  assign edg.lead = master ? m_lead : s_lead;
  assign edg.trail = master ? m_trail : s_trail;
  wire din = master ? somi_s_q[1] : simo_s_q[1];
  wire last = edg.trail & (bit_q == top_idx);
  wire load = wr_acc & hit_data;
  wire start = load & master & swrst_n & (st_q == spoc_pkg::SPOC_IDLE);
  // shifted word and new bit for the trailing edge
  wire trail_bit = phase ? samp_q : din;
  wire [CHR_W-1:0] sh_next = {sh_q[CHR_W-2:0], trail_bit};
  // received character, upper bits cleared
  wire [CHR_W-1:0] len_mask = CHR_W'((32'h1 << len) - 32'h1);

  // interrupt sources gated by enables and mask
  wire ovr_set = last & rx_full_q;
  wire sts_clr = rd_acc & hit_sts;
  wire ovr_irq = ovr_q & opc_q[`SPOC_OPC_OVR_EN] & mask_q[1];
  wire int_irq = intf_q & opc_q[`SPOC_OPC_INT_EN] & mask_q[0];

  // pin synchronisers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_s_q <= 3'h0;
      simo_s_q <= 2'h0;
      somi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], shift_clock_line_i};
      simo_s_q <= {simo_s_q[0], simo_i};
      somi_s_q <= {somi_s_q[0], somi_i};
    end
  end

  // bus handshake: one wait cycle, then answer
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= `SPOC_CFG_RST;
      opc_q <= `SPOC_OPC_RST;
      mask_q <= `SPOC_MASK_RST;
    end else if (wr_acc) begin
      if (hit_cfg) begin
        cfg_q <= {wbyte[7:6], 2'h0, wbyte[3:0]};
      end
      if (hit_opc) begin
        opc_q <= wbyte[`SPOC_OPC_W-1:0];
      end
      if (hit_mask) begin
        mask_q <= wbyte[`SPOC_STS_OVR:`SPOC_STS_INT];
      end
    end
  end

  // sticky flags; a set wins over a clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ovr_q <= 1'b0;
      intf_q <= 1'b0;
      rx_full_q <= 1'b0;
      rxbuf_q <= '0;
    end else begin
      ovr_q <= ovr_set | (ovr_q & ~sts_clr & swrst_n);
      intf_q <= last | (intf_q & ~sts_clr & swrst_n);
      rx_full_q <= last | (rx_full_q & ~(rd_acc & hit_data) & swrst_n);
      if (last) begin
        rxbuf_q <= sh_next & len_mask;
      end
    end
  end

  // one shared interrupt line
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ovr_irq | int_irq;
    end
  end

  // master clock generator
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= spoc_pkg::SPOC_IDLE;
      div_q <= '0;
      sclk_q <= 1'b0;
    end else if (!swrst_n || !master) begin
      st_q <= spoc_pkg::SPOC_IDLE;
      div_q <= '0;
      sclk_q <= pol;
    end else begin
      unique case (st_q)
        spoc_pkg::SPOC_IDLE: begin
          sclk_q <= pol;
          div_q <= '0;
          if (start) begin
            st_q <= spoc_pkg::SPOC_SHIFT;
          end
        end
        spoc_pkg::SPOC_SHIFT: begin
          div_q <= m_tick ? '0 : div_q + CNT_W'(1);
          if (m_tick) begin
            sclk_q <= ~sclk_q;
          end
          if (last) begin
            st_q <= spoc_pkg::SPOC_IDLE;
          end
        end
      endcase
    end
  end

  // shift engine
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sh_q <= '0;
      bit_q <= '0;
      samp_q <= 1'b0;
      out_q <= 1'b0;
    end else if (load) begin
      sh_q <= CHR_W'(avs_writedata_i);
      bit_q <= '0;
      if (phase) begin
        out_q <= bit_at(CHR_W'(avs_writedata_i), top_idx);
      end
    end else if (!swrst_n) begin
      bit_q <= '0;
    end else begin
      if (edg.lead) begin
        if (phase) begin
          samp_q <= din;
        end else begin
          out_q <= bit_at(sh_q, top_idx);
        end
      end
      if (edg.trail) begin
        sh_q <= sh_next;
        bit_q <= last ? '0 : bit_q + LEN_W'(1);
        if (phase && !last) begin
          out_q <= bit_at(sh_q, next_idx);
        end
      end
    end
  end

  // pin drivers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_pin_q <= '0;
      simo_pin_q <= '0;
      somi_pin_q <= '0;
    end else begin
      sclk_pin_q <= '{o: sclk_q, oe: master};
      simo_pin_q <= '{o: out_q, oe: master & talk};
      somi_pin_q <= '{o: out_q, oe: ~master & talk};
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign shift_clock_line_o = sclk_pin_q.o;
  assign shift_clock_line_oe_o = sclk_pin_q.oe;
  assign simo_o = simo_pin_q.o;
  assign simo_oe_o = simo_pin_q.oe;
  assign somi_o = somi_pin_q.o;
  assign somi_oe_o = somi_pin_q.oe;
  assign irq_o = irq_q;
endmodule : spoc_top
